//--- src/pao_pkg.sv
// Constants, types and timing counts for the pipelined converter output port.
// Assumes one 100 MHz sample clock and a synchronous active-high reset.
package pao_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned STAGE_BITS = 2;
    localparam int unsigned NUM_STAGES = DATA_W / STAGE_BITS;
    localparam int unsigned FILL_W = 3;
    localparam int unsigned SYNC_DEPTH = 2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Latency in half cycles, counted from the mid-cycle sampling instant
    localparam int unsigned LATENCY_HALF_CYCLES = 9;
    // Whole rising edges from the hold edge to the output register
    localparam int unsigned FILL_CYCLES = (LATENCY_HALF_CYCLES - 1) / 2;
    localparam logic [FILL_W-1:0] FILL_LAST = FILL_W'(FILL_CYCLES);

    // ************************************************************
    // Reset values and codes
    // ************************************************************
    localparam logic [DATA_W-1:0] CODE_BOTTOM = 8'h00;
    localparam logic [DATA_W-1:0] CODE_TOP = 8'hff;
    localparam logic [FILL_W-1:0] FILL_RESET = 3'h0;
    localparam logic [SYNC_DEPTH-1:0] SYNC_RESET = 2'h0;

    typedef enum logic [2:0]
    {
        PAO_ST_SLEEP = 3'b001,
        PAO_ST_FILL = 3'b010,
        PAO_ST_STREAM = 3'b100
    } pao_state_t;
endpackage : pao_pkg

//--- src/pao_stage.sv
// One pipeline stage: resolves two bits of the held residue.
// Assumes an enable from the parent that freezes the stage in standby.
module pao_stage
#(
    parameter int unsigned STAGE_IDX = 0
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic en_i,
    input wire logic [pao_pkg::DATA_W-1:0] residue_i,
    input wire logic [pao_pkg::DATA_W-1:0] word_i,
    output logic [pao_pkg::DATA_W-1:0] residue_o,
    output logic [pao_pkg::DATA_W-1:0] word_o
);
    import pao_pkg::*;

    localparam int unsigned MSB = DATA_W - 1 - STAGE_IDX * STAGE_BITS;

    logic [DATA_W-1:0] residue_d;
    logic [DATA_W-1:0] residue_q;
    logic [DATA_W-1:0] word_d;
    logic [DATA_W-1:0] word_q;

    // ************************************************************
    // Stage decision and residue
    // ************************************************************
    always_comb
    begin
        residue_d = residue_q;
        word_d = word_q;
        if (en_i)
        begin
            // Residue moves left so the next stage sees its own bits on top
            residue_d = {residue_i[DATA_W-STAGE_BITS-1:0], {STAGE_BITS{1'b0}}};
            // Each stage drops its code into the travelling word, so the
            // codes of one sample stay aligned without extra delay lines
            word_d = word_i;
            word_d[MSB -: STAGE_BITS] = residue_i[DATA_W-1 -: STAGE_BITS];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            residue_q <= CODE_BOTTOM;
            word_q <= CODE_BOTTOM;
        end
        else
        begin
            residue_q <= residue_d;
            word_q <= word_d;
        end
    end

    assign residue_o = residue_q;
    assign word_o = word_q;
endmodule : pao_stage

//--- src/pao_top.sv
// Digital side of an 8-bit pipelined sampling converter with parallel output.
// Assumes the analog sample-and-hold delivers a quantised level on ain_level_i,
// synchronous to clk_sys_i, and that the tracking phase is the clock high half.
module pao_top
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [pao_pkg::DATA_W-1:0] ain_level_i,
    input wire logic low_power_hold_request_i,
    input wire logic internal_reference_shutdown_i,
    input wire logic out_enable_n_i,
    output logic [pao_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic data_valid_o,
    output logic ref_shutdown_o,
    output logic standby_o
);
    import pao_pkg::*;

    logic [SYNC_DEPTH-1:0] stby_sync_d;
    logic [SYNC_DEPTH-1:0] stby_sync_q;
    logic [SYNC_DEPTH-1:0] refsd_sync_d;
    logic [SYNC_DEPTH-1:0] refsd_sync_q;
    logic run;
    pao_state_t state_d;
    pao_state_t state_q;
    logic [FILL_W-1:0] fill_d;
    logic [FILL_W-1:0] fill_q;
    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] residue [NUM_STAGES+1];
    logic [DATA_W-1:0] word [NUM_STAGES+1];

    // ************************************************************
    // Control pin synchronisers
    // ************************************************************
    // Pins are idle low, which means running on internal references
    always_comb
    begin
        stby_sync_d = {stby_sync_q[0], low_power_hold_request_i};
        refsd_sync_d = {refsd_sync_q[0], internal_reference_shutdown_i};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            stby_sync_q <= SYNC_RESET;
            refsd_sync_q <= SYNC_RESET;
        end
        else
        begin
            stby_sync_q <= stby_sync_d;
            refsd_sync_q <= refsd_sync_d;
        end
    end

    assign run = ~stby_sync_q[1];
    assign standby_o = stby_sync_q[1];
    assign ref_shutdown_o = refsd_sync_q[1];

    // ************************************************************
    // Conversion pipeline
    // ************************************************************
    // Stage 0 captures the level at the rising edge that ends the hold
    // phase; the sampling instant lies half a cycle earlier, at the end
    // of the tracking half, which makes the total latency 4.5 cycles
    assign residue[0] = ain_level_i;
    assign word[0] = CODE_BOTTOM;

    generate
        for (genvar k = 0; k < NUM_STAGES; k++)
        begin : g_stage
            pao_stage
            #(
                .STAGE_IDX(k)
            )
            u_stage
            (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .en_i(run),
                .residue_i(residue[k]),
                .word_i(word[k]),
                .residue_o(residue[k+1]),
                .word_o(word[k+1])
            );
        end
    endgenerate

    // ************************************************************
    // Fill tracking and output register
    // ************************************************************
    always_comb
    begin
        state_d = state_q;
        fill_d = fill_q;
        data_d = data_q;
        if (run)
        begin
            data_d = word[NUM_STAGES];
        end
        case (state_q)
            PAO_ST_SLEEP:
            begin
                fill_d = FILL_RESET;
                if (run)
                begin
                    state_d = PAO_ST_FILL;
                end
            end
            PAO_ST_FILL:
            begin
                if (!run)
                begin
                    state_d = PAO_ST_SLEEP;
                    fill_d = FILL_RESET;
                end
                else if (fill_q == FILL_LAST)
                begin
                    state_d = PAO_ST_STREAM;
                end
                else
                begin
                    fill_d = fill_q + 3'h1;
                end
            end
            PAO_ST_STREAM:
            begin
                // Stays valid every cycle until standby freezes the pipe
                if (!run)
                begin
                    state_d = PAO_ST_SLEEP;
                    fill_d = FILL_RESET;
                end
            end
            default:
            begin
                state_d = PAO_ST_FILL;
                fill_d = FILL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= PAO_ST_FILL;
            fill_q <= FILL_RESET;
            data_q <= CODE_BOTTOM;
        end
        else
        begin
            state_q <= state_d;
            fill_q <= fill_d;
            data_q <= data_d;
        end
    end

    assign data_o = data_q;
    assign data_valid_o = (state_q == PAO_ST_STREAM);
    // Not synchronised on purpose: the enable must float the bus even with
    // the clock stopped. Capture logic sees data_o changing on rising
    // edges and so samples it on the falling edge, mid-cycle.
    assign data_oe_o = ~out_enable_n_i;

    // ************************************************************
    // Checks
    // ************************************************************
    // Output register loads four edges after stage 0; its value is sampled one edge later
    a_latency_exact: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o |-> data_o == $past(ain_level_i, 5))
        else $error("output word does not match sample taken five edges earlier");

    a_word_binary: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o && $past(ain_level_i, 5) == CODE_TOP |-> data_o == CODE_TOP)
        else $error("top of range did not give the highest code");

    a_stage_align: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        run ##1 run |=> word[2][DATA_W-1 -: 4] == $past(ain_level_i[DATA_W-1 -: 4], 2))
        else $error("stage codes of one sample are not aligned");

    a_fill_time: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_q == PAO_ST_FILL && fill_q == FILL_RESET) ##0 run [*5] |=> data_valid_o)
        else $error("valid did not rise after the pipeline filled");

    a_valid_gapless: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o && run |=> data_valid_o)
        else $error("gap in valid output words");

    a_standby_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !run |=> $stable(data_o) && !data_valid_o)
        else $error("output changed or stayed valid during standby");

    a_standby_sync: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ##2 standby_o == $past(low_power_hold_request_i, 2))
        else $error("standby pin not seen two edges later");

    a_refsd_sync: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ##2 ref_shutdown_o == $past(internal_reference_shutdown_i, 2))
        else $error("reference shutdown pin not seen two edges later");

    a_oe_async: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_oe_o != out_enable_n_i)
        else $error("output enable does not follow its pin");

    c_fill_done: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(data_valid_o));
    c_standby_entry: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o ##1 !data_valid_o ##1 standby_o);
    c_bus_float: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o && !data_oe_o);
    c_top_code: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        data_valid_o && data_o == CODE_TOP);
endmodule : pao_top

//--- verif/pao_capture.sv
// Capture-side model that clocks in the converter's parallel word.
// Assumes the bench resolves the data bus from the drive enable.
module pao_capture
(
    input wire logic clk_sys_i,
    input wire logic [pao_pkg::DATA_W-1:0] bus_i,
    input wire logic valid_i,
    output logic [pao_pkg::DATA_W-1:0] word_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import pao_pkg::*;
    // ************************************************************
    // Capture register
    // ************************************************************
    // Falling edge: output delay stays under half a period at full rate
    always_ff @(negedge clk_sys_i)
    begin
        word_o <= bus_i;
        valid_o <= valid_i;
    end
endmodule : pao_capture

//--- verif/tb_top.sv
// Self-checking bench for the converter output port.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s exp=%h got=%h", nm, ex, gt); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pao_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [DATA_W-1:0] ain = 8'h00;
    logic stby = 1'b0;
    logic rsd = 1'b0;
    logic oe_n = 1'b0;
    logic [DATA_W-1:0] dout, bus, cap;
    logic oe, vld, rso, sbo, cap_v;
    int mismatches = 0;
    int n_checks = 0;
    // ************************************************************
    // Clock, bus and instances
    // ************************************************************
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Released bus shows the inverse so a stale value cannot pass
    assign bus = oe ? dout : ~dout;
    pao_top u_pao_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ain_level_i(ain),
        .low_power_hold_request_i(stby), .internal_reference_shutdown_i(rsd),
        .out_enable_n_i(oe_n), .data_o(dout), .data_oe_o(oe), .data_valid_o(vld),
        .ref_shutdown_o(rso), .standby_o(sbo));
    pao_capture u_pao_capture (.clk_sys_i(clk_sys_i), .bus_i(bus), .valid_i(vld),
        .word_o(cap), .valid_o(cap_v));
    // ************************************************************
    // Scenarios
    // ************************************************************
    function automatic logic [DATA_W-1:0] smp(input int i);
        return (i % 9 == 3) ? CODE_BOTTOM : (i % 9 == 4) ? CODE_TOP : 8'(i * 37);
    endfunction : smp
    task automatic t_defaults();
        `CHK("standby", 1'b0, sbo)
        `CHK("ref_off", 1'b0, rso)
        `CHK("drive_en", 1'b1, oe)
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_stream();
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_sys_i);
            ain = smp(i);
            #1;
            if (i >= 5)
            begin
                `CHK("word", smp(i - 5), cap)
                `CHK("valid", 1'b1, cap_v)
            end
        end
        $display("test stream done");
    endtask : t_stream
    task automatic t_oe();
        // Float across a rising edge so the bus is released while words move
        @(negedge clk_sys_i);
        oe_n = 1'b1;
        #1 `CHK("oe_off", 1'b0, oe)
        `CHK("bus_float", ~dout, bus)
        @(negedge clk_sys_i);
        `CHK("still_off", 1'b0, oe)
        oe_n = 1'b0;
        #1 `CHK("oe_on", 1'b1, oe)
        `CHK("bus_back", dout, bus)
        $display("test output enable done");
    endtask : t_oe
    task automatic t_ref();
        @(negedge clk_sys_i);
        rsd = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        `CHK("ref_on", 1'b1, rso)
        `CHK("ref_valid", 1'b1, vld)
        rsd = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        `CHK("ref_off2", 1'b0, rso)
        $display("test reference done");
    endtask : t_ref
    task automatic t_standby();
        logic [DATA_W-1:0] held;
        int n;
        @(negedge clk_sys_i);
        stby = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        `CHK("sleep", 1'b1, sbo)
        `CHK("sleep_valid", 1'b0, vld)
        held = dout;
        for (int i = 0; i < 5; i++)
        begin
            ain = ~ain;
            @(negedge clk_sys_i);
        end
        `CHK("frozen", held, dout)
        stby = 1'b0;
        n = 0;
        while (vld !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        // Two sync edges, one to leave sleep, five fill edges
        `CHK("refill", 8, n)
        $display("test standby done");
    endtask : t_standby
    // ************************************************************
    // Run control
    // ************************************************************
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial
    begin
        // Whole run is about 130 cycles; allow ample margin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        t_defaults();
        t_stream();
        t_oe();
        t_ref();
        t_standby();
        t_stream();
        end_of_test();
    end
endmodule : tb_top
